// file: design/psl_strap_led.sv
// strap capture, speed/duplex defaults and indicator drive on shared pins
// assumes an axi4-lite master and core status inputs on clk_in
// Operation
// - autoneg on: pattern 10 advertises gigabit, 01 adds 100, 00 all three
// - autoneg on, both speed straps high: advertise gigabit and 10 only
// - autoneg off: 10 forces gigabit, 01 forces 100, 00 forces 10, 11 reserved
// - low speed strap readable at bit 12 of strap status register
// - high speed strap readable at bit 13 of strap status register
// - activity indicator lights on idle error or packet transfer
// - standard mode: 10 Mbps indicator lights on good 10 Mbps link
// - reduced indicator modes chosen by led config bit 5 and mode bit 0
// - three-in-one merges all good links; four-in-one also merges activity
// - four-in-one: combined indicator steady on for link, flashing during activity; three-in-one stays steady
// - duplex strap 1 defaults full duplex, 0 restricts to half duplex
// - duplex strap readable at bit 14 of strap status register
// - 100 Mbps indicator lights after signal detect held 500 us
// - 100 Mbps indicator drops at once when signal detect drops
// - autoneg enable bit initialised from the autoneg strap
// - software write of control bit 12 overrides the strapped autoneg
// - autoneg strap readable at bit 15 of strap status register
// - gigabit indicator needs training, autoneg done, valid link, reliable rx
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
module psl_strap_led
  import psl_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES  = HUNDRED_QUAL_CYCLES,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // dual-purpose pins: 0 speed low/activity, 1 speed high/10M, 2 duplex/100M, 3 autoneg/1G
  input  wire logic [3:0]  strap_led_pin_in,
  output logic [3:0]       strap_led_pin_out,
  output logic [3:0]       strap_led_pin_oe_out,
  // core status
  input  wire logic        idle_error_in,
  input  wire logic        packet_xfer_in,
  input  wire logic        link10_good_in,
  input  wire logic        signal_detect_in,
  input  wire logic        training_done_in,
  input  wire logic        autoneg_done_in,
  input  wire logic        gig_link_valid_in,
  input  wire logic        remote_rx_ok_in,
  // resolved configuration
  output logic             autoneg_enable_out,
  output logic [2:0]       advertise_out,
  output logic [2:0]       force_speed_out,
  output logic             full_duplex_default_out
);
  localparam logic [19:0] QUAL_LAST  = 20'(QUAL_CYCLES - 1);
  localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYCLES - 1);

  psl_phase_t  phase_reg;
  psl_phase_t  phase_next;
  logic [3:0]  settle_cnt_reg;
  logic [3:0]  pin_level;
  logic [3:0]  strap_reg;
  logic        an_en_reg;
  logic        reduced_reg;
  logic        four_reg;
  logic [2:0]  advertise_reg;
  logic [2:0]  force_reg;
  logic        full_duplex_reg;
  logic [19:0] sd_cnt_reg;
  logic        link100_lit_reg;
  logic        gig_lit_reg;
  logic [23:0] blink_cnt_reg;
  logic        blink_phase_reg;
  logic        act_recent_reg;
  logic [3:0]  pin_out_reg;
  logic [3:0]  pin_oe_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // pin synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
      psl_pin_sync u_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (strap_led_pin_in[gi]),
        .level_out (pin_level[gi])
      );
    end
  endgenerate

  // strap phase: pins stay undriven until the straps are caught
  wire led_phase   = (phase_reg == PH_LED);
  wire settle_done = (settle_cnt_reg == SETTLE_LAST);
  wire capture     = (phase_reg == PH_SETTLE) && settle_done;

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_SETTLE: if (settle_done) phase_next = PH_LED;
      PH_LED:    phase_next = PH_LED;
      default:   phase_next = PH_SETTLE;
    endcase
  end

  // write channel decode
  wire       aw_take  = s_axi_awvalid_in && awready_reg;
  wire       w_take   = s_axi_wvalid_in && wready_reg;
  wire       wr_fire  = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire       b_done   = bvalid_reg && s_axi_bready_in;
  wire [5:0] wr_idx   = aw_addr_reg[7:2];
  wire       wr_ctrl  = wr_fire && (wr_idx == IDX_CTRL);
  wire       wr_cfg   = wr_fire && (wr_idx == IDX_LED_CFG);
  wire       wr_mode  = wr_fire && (wr_idx == IDX_LED_MODE);
  wire       wr_map   = (wr_idx == IDX_CTRL) || (wr_idx == IDX_STRAP) ||
                        (wr_idx == IDX_RESOLVED) || (wr_idx == IDX_LED_CFG) ||
                        (wr_idx == IDX_LED_MODE);

  // read channel decode
  wire        ar_take = s_axi_arvalid_in && arready_reg;
  wire        r_done  = rvalid_reg && s_axi_rready_in;
  wire [5:0]  rd_idx  = s_axi_araddr_in[7:2];
  wire [31:0] strap_word =
      (32'(strap_reg[PIN_SPEED_LO]) << STRAP_SPEED_LO_BIT) |
      (32'(strap_reg[PIN_SPEED_HI]) << STRAP_SPEED_HI_BIT) |
      (32'(strap_reg[PIN_DUPLEX]) << STRAP_DUPLEX_BIT) |
      (32'(strap_reg[PIN_AUTONEG]) << STRAP_AN_BIT);
  wire [31:0] ctrl_word     = 32'(an_en_reg) << CTRL_AN_EN_BIT;
  wire [31:0] cfg_word      = 32'(reduced_reg) << LED_REDUCED_BIT;
  wire [31:0] mode_word     = 32'(four_reg) << LED_FOUR_BIT;
  wire [31:0] resolved_word = {21'h0, pin_out_reg, led_phase, force_reg, advertise_reg};
  wire        rd_map  = (rd_idx == IDX_CTRL) || (rd_idx == IDX_STRAP) ||
                        (rd_idx == IDX_RESOLVED) || (rd_idx == IDX_LED_CFG) ||
                        (rd_idx == IDX_LED_MODE);
  wire [31:0] rd_word = (rd_idx == IDX_CTRL)     ? ctrl_word :
                        (rd_idx == IDX_STRAP)    ? strap_word :
                        (rd_idx == IDX_RESOLVED) ? resolved_word :
                        (rd_idx == IDX_LED_CFG)  ? cfg_word :
                        (rd_idx == IDX_LED_MODE) ? mode_word : 32'h0;

  // speed and duplex resolution from the held straps
  wire [1:0] strap_speed = {strap_reg[PIN_SPEED_HI], strap_reg[PIN_SPEED_LO]};
  wire [2:0] adv_pattern = (strap_speed == SPD_GIG)  ? 3'h4 :
                           (strap_speed == SPD_HUND) ? 3'h6 :
                           (strap_speed == SPD_TEN)  ? 3'h7 :
                           3'h5;
  // reserved pattern forces nothing; the core keeps its own default
  wire [2:0] force_pattern = (strap_speed == SPD_GIG)  ? 3'h4 :
                             (strap_speed == SPD_HUND) ? 3'h2 :
                             (strap_speed == SPD_TEN)  ? 3'h1 : 3'h0;
  wire [2:0] advertise_next = (led_phase && an_en_reg) ? adv_pattern : 3'h0;
  wire [2:0] force_next     = (led_phase && !an_en_reg) ? force_pattern : 3'h0;
  wire       duplex_next    = led_phase && strap_reg[PIN_DUPLEX];

  // indicator sources
  wire activity    = idle_error_in || packet_xfer_in;
  wire blink_tick  = (blink_cnt_reg == BLINK_LAST);
  wire any_link    = link10_good_in || link100_lit_reg || gig_lit_reg;
  wire flash_off   = act_recent_reg && blink_phase_reg;
  wire combined    = four_reg ? (any_link && !flash_off) : any_link;
  wire ten_lit     = reduced_reg ? combined : link10_good_in;
  wire hund_lit    = !reduced_reg && link100_lit_reg;
  wire gig_lit     = !reduced_reg && gig_lit_reg;
  wire [3:0] led_lit = {gig_lit, hund_lit, ten_lit, act_recent_reg};
  wire sd_full     = (sd_cnt_reg >= QUAL_LAST);
  wire gig_ok      = training_done_in && autoneg_done_in &&
                     gig_link_valid_in && remote_rx_ok_in;

  // strap capture and control bits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg      <= PH_SETTLE;
      settle_cnt_reg <= 4'h0;
      strap_reg      <= 4'h0;
      an_en_reg      <= CTRL_AN_EN_RST;
      reduced_reg    <= LED_REDUCED_RST;
      four_reg       <= LED_FOUR_RST;
    end else begin
      phase_reg <= phase_next;
      if (!settle_done) settle_cnt_reg <= settle_cnt_reg + 4'h1;
      if (capture) begin
        strap_reg <= pin_level;
        an_en_reg <= pin_level[PIN_AUTONEG];
      end else if (wr_ctrl && wstrb_reg[1]) begin
        an_en_reg <= wdata_reg[CTRL_AN_EN_BIT];
      end
      if (wr_cfg && wstrb_reg[0]) reduced_reg <= wdata_reg[LED_REDUCED_BIT];
      if (wr_mode && wstrb_reg[0]) four_reg <= wdata_reg[LED_FOUR_BIT];
    end
  end

  // resolved configuration outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      advertise_reg   <= 3'h0;
      force_reg       <= 3'h0;
      full_duplex_reg <= 1'h0;
    end else begin
      advertise_reg   <= advertise_next;
      force_reg       <= force_next;
      full_duplex_reg <= duplex_next;
    end
  end

  // link qualification and blink timing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sd_cnt_reg      <= 20'h0;
      link100_lit_reg <= 1'h0;
      gig_lit_reg     <= 1'h0;
      blink_cnt_reg   <= 24'h0;
      blink_phase_reg <= 1'h0;
      act_recent_reg  <= 1'h0;
    end else begin
      if (!signal_detect_in) sd_cnt_reg <= 20'h0;
      else if (!sd_full) sd_cnt_reg <= sd_cnt_reg + 20'h1;
      link100_lit_reg <= signal_detect_in && sd_full;
      gig_lit_reg     <= gig_ok;
      blink_cnt_reg   <= blink_tick ? 24'h0 : blink_cnt_reg + 24'h1;
      if (blink_tick) blink_phase_reg <= !blink_phase_reg;
      // stretched so a single-cycle event is still visible; new event wins over expiry
      if (activity) act_recent_reg <= 1'h1;
      else if (blink_tick) act_recent_reg <= 1'h0;
    end
  end

  // pin drive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out_reg <= 4'h0;
      pin_oe_reg  <= 4'h0;
    end else begin
      pin_out_reg <= led_phase ? led_lit : 4'h0;
      pin_oe_reg  <= {4{phase_next == PH_LED}};
    end
  end

  // axi4-lite write path
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_reg <= 1'h1;
      wready_reg  <= 1'h1;
      aw_hold_reg <= 1'h0;
      w_hold_reg  <= 1'h0;
      aw_addr_reg <= 8'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'h0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr_in;
        aw_hold_reg <= 1'h1;
        awready_reg <= 1'h0;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'h0;
      end
      if (w_take) begin
        wdata_reg  <= s_axi_wdata_in;
        wstrb_reg  <= s_axi_wstrb_in;
        w_hold_reg <= 1'h1;
        wready_reg <= 1'h0;
      end else if (wr_fire) begin
        w_hold_reg <= 1'h0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'h1;
        bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_reg  <= 1'h0;
        awready_reg <= 1'h1;
        wready_reg  <= 1'h1;
      end
    end
  end

  // axi4-lite read path
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_reg <= 1'h1;
      rvalid_reg  <= 1'h0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'h0;
      rvalid_reg  <= 1'h1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'h1;
      rvalid_reg  <= 1'h0;
    end
  end

  assign s_axi_awready_out       = awready_reg;
  assign s_axi_wready_out        = wready_reg;
  assign s_axi_bresp_out         = bresp_reg;
  assign s_axi_bvalid_out        = bvalid_reg;
  assign s_axi_arready_out       = arready_reg;
  assign s_axi_rdata_out         = rdata_reg;
  assign s_axi_rresp_out         = rresp_reg;
  assign s_axi_rvalid_out        = rvalid_reg;
  assign strap_led_pin_out       = pin_out_reg;
  assign strap_led_pin_oe_out    = pin_oe_reg;
  assign autoneg_enable_out      = an_en_reg;
  assign advertise_out           = advertise_reg;
  assign force_speed_out         = force_reg;
  assign full_duplex_default_out = full_duplex_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  strap_hold_a: assert property (led_phase |=> $stable(strap_reg))
    else $error("straps changed after capture");
  oe_gate_a: assert property (|pin_oe_reg |-> led_phase)
    else $error("pin driven before straps held");
  adv_gig_a: assert property (led_phase && an_en_reg && strap_speed == SPD_GIG
    |=> advertise_reg == 3'h4) else $error("wrong advertise for pattern 10");
  adv_gig_ten_a: assert property (led_phase && an_en_reg && strap_speed == SPD_RSVD
    |=> advertise_reg == 3'h5) else $error("wrong advertise for pattern 11");
  force_map_a: assert property (led_phase && !an_en_reg && strap_speed == SPD_HUND
    |=> force_reg == 3'h2 && advertise_reg == 3'h0) else $error("wrong forced speed");
  speed_lo_rd_a: assert property ($rose(rvalid_reg) && $past(rd_idx == IDX_STRAP && led_phase)
    |-> rdata_reg[STRAP_SPEED_LO_BIT] == strap_reg[PIN_SPEED_LO]) else $error("bad bit 12");
  speed_hi_rd_a: assert property ($rose(rvalid_reg) && $past(rd_idx == IDX_STRAP && led_phase)
    |-> rdata_reg[STRAP_SPEED_HI_BIT] == strap_reg[PIN_SPEED_HI]) else $error("bad bit 13");
  duplex_rd_a: assert property ($rose(rvalid_reg) && $past(rd_idx == IDX_STRAP && led_phase)
    |-> rdata_reg[STRAP_DUPLEX_BIT] == strap_reg[PIN_DUPLEX]) else $error("bad bit 14");
  an_rd_a: assert property ($rose(rvalid_reg) && $past(rd_idx == IDX_STRAP && led_phase)
    |-> rdata_reg[STRAP_AN_BIT] == strap_reg[PIN_AUTONEG]) else $error("bad bit 15");
  act_led_a: assert property (led_phase && activity |=> ##1 pin_out_reg[PIN_SPEED_LO])
    else $error("activity not shown");
  ten_led_a: assert property (led_phase && !reduced_reg && link10_good_in
    |=> pin_out_reg[PIN_SPEED_HI]) else $error("10M link not shown");
  mode_sel_a: assert property (led_phase && reduced_reg
    |=> !pin_out_reg[PIN_DUPLEX] && !pin_out_reg[PIN_AUTONEG]) else $error("reduced mode leak");
  three_one_a: assert property (led_phase && reduced_reg && !four_reg && gig_lit_reg
    |=> pin_out_reg[PIN_SPEED_HI]) else $error("combined link not shown");
  flash_off_a: assert property (led_phase && reduced_reg && four_reg && flash_off
    |=> !pin_out_reg[PIN_SPEED_HI]) else $error("combined not flashing");
  duplex_def_a: assert property (led_phase
    |=> full_duplex_reg == $past(strap_reg[PIN_DUPLEX])) else $error("duplex default wrong");
  hund_qual_a: assert property ($rose(link100_lit_reg) |-> $past(sd_cnt_reg) == QUAL_LAST)
    else $error("100M lit too early");
  hund_drop_a: assert property (!signal_detect_in |=> !link100_lit_reg)
    else $error("100M lit without signal detect");
  an_init_a: assert property ($rose(led_phase) |-> an_en_reg == strap_reg[PIN_AUTONEG])
    else $error("autoneg not taken from strap");
  an_write_a: assert property (led_phase && wr_ctrl && wstrb_reg[1]
    |=> an_en_reg == $past(wdata_reg[CTRL_AN_EN_BIT])) else $error("autoneg write lost");
  gig_gate_a: assert property (gig_lit_reg |-> $past(gig_ok))
    else $error("gigabit lit without all conditions");
endmodule

// file: design/psl_pkg.sv
// constants shared by the strap and indicator logic
// assumes a 100 MHz core clock and word-aligned axi4-lite access
package psl_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned HUNDRED_QUAL_US     = 500;
  localparam int unsigned HUNDRED_QUAL_CYCLES =
      (HUNDRED_QUAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_MS       = 50;
  localparam int unsigned BLINK_HALF_CYCLES   = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE_CYCLES = 8;
  localparam logic [3:0]  SETTLE_LAST         = 4'(STRAP_SETTLE_CYCLES - 1);

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL     = 6'h00;
  localparam logic [5:0] IDX_STRAP    = 6'h10;
  localparam logic [5:0] IDX_RESOLVED = 6'h11;
  localparam logic [5:0] IDX_LED_CFG  = 6'h13;
  localparam logic [5:0] IDX_LED_MODE = 6'h1a;

  // field positions
  localparam int unsigned CTRL_AN_EN_BIT     = 12;
  localparam int unsigned STRAP_SPEED_LO_BIT = 12;
  localparam int unsigned STRAP_SPEED_HI_BIT = 13;
  localparam int unsigned STRAP_DUPLEX_BIT   = 14;
  localparam int unsigned STRAP_AN_BIT       = 15;
  localparam int unsigned LED_REDUCED_BIT    = 5;
  localparam int unsigned LED_FOUR_BIT       = 0;

  // values after reset
  localparam logic CTRL_AN_EN_RST  = 1'h0;
  localparam logic LED_REDUCED_RST = 1'h0;
  localparam logic LED_FOUR_RST    = 1'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // dual-purpose pin positions
  localparam int unsigned PIN_CNT      = 4;
  localparam int unsigned PIN_SPEED_LO = 0;
  localparam int unsigned PIN_SPEED_HI = 1;
  localparam int unsigned PIN_DUPLEX   = 2;
  localparam int unsigned PIN_AUTONEG  = 3;

  // speed strap patterns {high, low}
  localparam logic [1:0] SPD_TEN  = 2'h0;
  localparam logic [1:0] SPD_HUND = 2'h1;
  localparam logic [1:0] SPD_GIG  = 2'h2;
  localparam logic [1:0] SPD_RSVD = 2'h3;

  typedef enum logic [1:0] {
    PH_SETTLE = 2'h1,
    PH_LED    = 2'h2
  } psl_phase_t;
endpackage

// file: design/psl_pin_sync.sv
// three-stage synchroniser for one board pin
// assumes the pin is asynchronous to clk_in
module psl_pin_sync
  import psl_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // pin and clean level
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // level moves only once the last two stages agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg    <= 1'h0;
      s2_reg    <= 1'h0;
      s3_reg    <= 1'h0;
      level_reg <= 1'h0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_out = level_reg;
endmodule

// file: verification/psl_board_model.sv
// board side of the shared pins: strap resistors and indicator lamps
// assumes the device drives all four pins once its straps are held
module psl_board_model (
  // strap levels and device drive
  input  wire logic [3:0] strap_in,
  input  wire logic [3:0] drive_in,
  input  wire logic [3:0] oe_in,
  // pin level and lamp state
  output logic [3:0]      pin_out,
  output logic [3:0]      lamp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // resistor wins only while the device lets the pin float
  assign pin_out  = (oe_in & drive_in) | (~oe_in & strap_in);
  assign lamp_out = oe_in & drive_in;
endmodule

// file: verification/test_phy_strap_and_led_logic.sv
// testbench: strap rows, register access and indicator behaviour
// assumes short qualify and blink counts so the run stays brief
module test_phy_strap_and_led_logic import psl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'h0, rst_n_in = 1'h0, s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
  logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
  logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
  logic [3:0] s_axi_wstrb_in = 4'hf, strap = 4'h0, strap_led_pin_in, strap_led_pin_out;
  logic [3:0] strap_led_pin_oe_out, lamp;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, autoneg_enable_out, full_duplex_default_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
  logic idle_error_in = 1'h0, packet_xfer_in = 1'h0, link10_good_in = 1'h0;
  logic signal_detect_in = 1'h0, training_done_in = 1'h0, autoneg_done_in = 1'h0;
  logic gig_link_valid_in = 1'h0, remote_rx_ok_in = 1'h0;
  logic [2:0] advertise_out, force_speed_out;
  int bad_count = 0, checks = 0;
  // {straps autoneg,duplex,high,low ; advertised ; forced}
  logic [9:0] rows [8] = '{{4'he, 3'h4, 3'h0}, {4'h9, 3'h6, 3'h0}, {4'hc, 3'h7, 3'h0},
    {4'hb, 3'h5, 3'h0}, {4'h6, 3'h0, 3'h4}, {4'h1, 3'h0, 3'h2}, {4'h4, 3'h0, 3'h1},
    {4'h3, 3'h0, 3'h0}};
  psl_strap_led #(.QUAL_CYCLES(20), .BLINK_CYCLES(8)) psl_strap_led_inst (.clk_in, .rst_n_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .strap_led_pin_in,
    .strap_led_pin_out, .strap_led_pin_oe_out, .idle_error_in, .packet_xfer_in,
    .link10_good_in, .signal_detect_in, .training_done_in, .autoneg_done_in,
    .gig_link_valid_in, .remote_rx_ok_in, .autoneg_enable_out, .advertise_out,
    .force_speed_out, .full_duplex_default_out);
  psl_board_model psl_board_model_inst (.strap_in(strap), .drive_in(strap_led_pin_out),
    .oe_in(strap_led_pin_oe_out), .pin_out(strap_led_pin_in), .lamp_out(lamp));
  always #5 clk_in = ~clk_in;
  task automatic test_done();
    $display("mismatches %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a wait that runs out ends the run at once
  task automatic lim(input int n);
    if (n >= 50) begin
      chk(n, 0);
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready_out === 1'h1) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out === 1'h1) s_axi_wvalid_in <= 1'h0;
    end while (s_axi_bvalid_out !== 1'h1 && n < 50);
    s_axi_bready_in <= 1'h0;
    resp = s_axi_bresp_out;
    lim(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready_out === 1'h1) s_axi_arvalid_in <= 1'h0;
    end while (s_axi_rvalid_out !== 1'h1 && n < 50);
    s_axi_rready_in <= 1'h0;
    rd = s_axi_rdata_out;
    resp = s_axi_rresp_out;
    lim(n);
  endtask
  task automatic see(input int i, input logic v, input int m);
    int n;
    n = 0;
    while (lamp[i] !== v && n < m) begin
      @(posedge clk_in);
      n++;
    end
    chk(lamp[i], v);
  endtask
  initial begin
    foreach (rows[k]) begin
      strap <= rows[k][9:6];
      rst_n_in <= 1'h0;
      repeat (12) @(posedge clk_in);
      chk(strap_led_pin_oe_out, 4'h0);
      rst_n_in <= 1'h1;
      repeat (16) @(posedge clk_in);
      rdr({IDX_STRAP, 2'h0});
      chk(rd[15:12], rows[k][9:6]);
      chk(advertise_out, rows[k][5:3]);
      chk(force_speed_out, rows[k][2:0]);
      chk(full_duplex_default_out, rows[k][8]);
      chk(autoneg_enable_out, rows[k][9]);
      chk(strap_led_pin_oe_out, 4'hf);
    end
    wr({IDX_CTRL, 2'h0}, 32'h1000);
    chk(autoneg_enable_out, 1'h1);
    chk(resp, RESP_OKAY);
    rdr({IDX_CTRL, 2'h0});
    chk(rd[12], 1'h1);
    chk(advertise_out, 3'h5);
    chk(force_speed_out, 3'h0);
    rdr(8'h08);
    chk(resp, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h08, 32'h0);
    chk(resp, RESP_SLVERR);
    // qualify count is 20 here: lamp must still be dark after 21 edges
    signal_detect_in <= 1'h1;
    repeat (21) @(posedge clk_in);
    chk(lamp[2], 1'h0);
    see(2, 1'h1, 2);
    signal_detect_in <= 1'h0;
    see(2, 1'h0, 3);
    {training_done_in, autoneg_done_in, gig_link_valid_in} <= 3'h7;
    repeat (6) @(posedge clk_in);
    chk(lamp[3], 1'h0);
    remote_rx_ok_in <= 1'h1;
    see(3, 1'h1, 4);
    link10_good_in <= 1'h1;
    see(1, 1'h1, 4);
    link10_good_in <= 1'h0;
    packet_xfer_in <= 1'h1;
    see(0, 1'h1, 4);
    packet_xfer_in <= 1'h0;
    see(0, 1'h0, 40);
    idle_error_in <= 1'h1;
    see(0, 1'h1, 4);
    wr({IDX_LED_CFG, 2'h0}, 32'h20);
    chk(resp, RESP_OKAY);
    see(1, 1'h1, 4);
    chk(lamp[3:2], 2'h0);
    repeat (20) begin
      @(posedge clk_in);
      chk(lamp[1], 1'h1);
    end
    wr({IDX_LED_MODE, 2'h0}, 32'h1);
    see(1, 1'h0, 40);
    see(1, 1'h1, 40);
    test_done();
  end
endmodule
